//--- src/dvs_selector.sv
// display value selector: chooses the quantity shown on the two-line display,
// returns to a scaled main value after inactivity, cycles service messages and
// issues configuration file save and load requests
// assumes step and view buttons are one-cycle presses and the load button is held through boot, synchronous to clk_sys, a serial register
// front end that has already decoded register numbers, and a file store that answers
// each request with a done pulse
`timescale 1ns/10ps
`default_nettype none
`include "dvs_regs.svh"
module dvs_selector #(
  parameter int unsigned IDLE_CYC = `DVS_IDLE_CYC,
  parameter int unsigned MSG_PERIOD_CYC = `DVS_MSG_PERIOD_CYC,
  parameter int unsigned MSG_SHOW_CYC = `DVS_MSG_SHOW_CYC,
  parameter int XW = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // front-panel buttons
  input wire logic key_next,
  input wire logic key_prev,
  input wire logic key_min,
  input wire logic key_max,
  input wire logic key_load_hold,
  // serial register access
  input wire logic reg_wr,
  input wire logic [`DVS_ADDR_W-1:0] reg_addr,
  input wire dvs_pkg::dvs_word_t reg_wdata,
  output dvs_pkg::dvs_word_t reg_rdata,
  // remembered selection and fitted options
  input wire dvs_pkg::dvs_qty_t saved_qty,
  input wire logic temp_fitted,
  output dvs_pkg::dvs_qty_t remember_qty,
  // measurement
  output dvs_pkg::dvs_qty_t meas_qty,
  input wire logic signed [XW-1:0] meas_value,
  // display
  output dvs_pkg::dvs_qty_t disp_qty,
  output dvs_pkg::dvs_view_e disp_view,
  output logic icon_min,
  output logic icon_max,
  output logic show_main,
  output dvs_pkg::dvs_word_t main_unit,
  output logic signed [XW+16:0] main_value,
  output dvs_pkg::dvs_msg_e disp_msg,
  // service status
  input wire logic restore_needed,
  input wire logic defaults_done,
  // configuration file store
  output logic save_req,
  output logic save_replace,
  input wire logic save_done,
  output logic load_req,
  input wire logic load_done,
  input wire logic load_ok,
  input wire dvs_pkg::dvs_word_t file_main_sel,
  input wire dvs_pkg::dvs_word_t file_main_unit,
  input wire dvs_pkg::dvs_word_t file_main_gain,
  input wire dvs_pkg::dvs_word_t file_main_offs
);
  import dvs_pkg::*;

  typedef struct packed {
    dvs_phase_e phase;
    dvs_qty_t qty;
    dvs_view_e view;
    logic main_on;
    logic [30:0] idle_cnt;
    logic [30:0] msg_cnt;
    logic done_seen;
    dvs_msg_e load_msg;
    logic [30:0] load_msg_cnt;
    dvs_word_t main_sel;
    dvs_word_t main_unit;
    dvs_word_t main_gain;
    dvs_word_t main_offs;
    logic save_req;
    logic save_busy;
    logic load_req;
    dvs_word_t rdata;
  } dvs_sel_s;

  dvs_sel_s st_reg;
  dvs_sel_s st_next;
  logic key_any;
  logic main_cfg;
  dvs_qty_t main_qty;

  // list step that skips temperature on units without the sensor
  function automatic dvs_qty_t step_qty(input dvs_qty_t q, input logic fwd, input logic temp);
    dvs_qty_t r;
    if (fwd) begin
      r = (q == `DVS_QTY_LAST) ? 5'h00 : 5'(q + 5'h01);
    end else begin
      r = (q == 5'h00) ? `DVS_QTY_LAST : 5'(q - 5'h01);
    end
    if (!temp && r == `DVS_QTY_TEMP) begin
      r = fwd ? 5'(r + 5'h01) : 5'(r - 5'h01);
    end
    return r;
  endfunction

  assign key_any = key_next | key_prev | key_min | key_max;
  assign main_cfg = (st_reg.main_sel != 16'h0000) && (st_reg.main_sel <= `DVS_MAIN_SEL_MAX);
  assign main_qty = 5'(st_reg.main_sel - 16'h0001);

  always_comb begin
    st_next = st_reg;
    st_next.save_req = 1'b0;
    st_next.load_req = 1'b0;
    unique case (st_reg.phase)
      DVS_PH_BOOT: begin
        // the remembered selection is caught after reset release, never under reset
        st_next.qty = (saved_qty > `DVS_QTY_LAST ||
                       (!temp_fitted && saved_qty == `DVS_QTY_TEMP)) ? 5'h00 : saved_qty;
        st_next.main_on = main_cfg;
        if (key_load_hold) begin
          st_next.phase = DVS_PH_LOAD;
          st_next.load_req = 1'b1;
        end else begin
          st_next.phase = DVS_PH_RUN;
        end
      end
      DVS_PH_LOAD: begin
        if (load_done) begin
          st_next.phase = DVS_PH_RUN;
          st_next.load_msg_cnt = 31'h0;
          if (load_ok) begin
            st_next.main_sel = file_main_sel;
            st_next.main_unit = file_main_unit;
            st_next.main_gain = file_main_gain;
            st_next.main_offs = file_main_offs;
            st_next.main_on = (file_main_sel != 16'h0000) && (file_main_sel <= `DVS_MAIN_SEL_MAX);
            st_next.load_msg = DVS_MSG_LOAD_OK;
          end else begin
            st_next.load_msg = DVS_MSG_LOAD_FAIL;
          end
        end
      end
      DVS_PH_RUN: begin
        if (st_reg.load_msg != DVS_MSG_NONE) begin
          st_next.load_msg_cnt = 31'(st_reg.load_msg_cnt + 31'h1);
          if (st_reg.load_msg_cnt == 31'(MSG_SHOW_CYC - 1)) begin
            st_next.load_msg = DVS_MSG_NONE;
          end
        end
        if (key_next || key_prev) begin
          // stepping from the main value starts from the quantity behind it
          st_next.qty = step_qty(st_reg.main_on ? main_qty : st_reg.qty, key_next,
                                 temp_fitted);
          st_next.view = DVS_VIEW_LIVE;
          st_next.main_on = 1'b0;
        end else if (key_min || key_max) begin
          if (st_reg.main_on) begin
            st_next.qty = main_qty;
          end
          st_next.view = key_max ? DVS_VIEW_MAX : DVS_VIEW_MIN;
          st_next.main_on = 1'b0;
        end
        if (key_any) begin
          st_next.idle_cnt = 31'h0;
        end else if (main_cfg && !st_reg.main_on) begin
          if (st_reg.idle_cnt == 31'(IDLE_CYC - 1)) begin
            st_next.main_on = 1'b1;
            st_next.view = DVS_VIEW_LIVE;
            st_next.idle_cnt = 31'h0;
          end else begin
            st_next.idle_cnt = 31'(st_reg.idle_cnt + 31'h1);
          end
        end
      end
      default: st_next.phase = DVS_PH_RUN;
    endcase
    // message slot counter free-runs so both service messages share one rhythm
    st_next.msg_cnt = (st_reg.msg_cnt == 31'(MSG_PERIOD_CYC - 1)) ? 31'h0 :
                      31'(st_reg.msg_cnt + 31'h1);
    if (defaults_done) begin
      st_next.done_seen = 1'b1;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `DVS_REG_MAIN_SEL: st_next.main_sel = reg_wdata;
        `DVS_REG_MAIN_UNIT: st_next.main_unit = reg_wdata;
        `DVS_REG_MAIN_GAIN: st_next.main_gain = reg_wdata;
        `DVS_REG_MAIN_OFFS: st_next.main_offs = reg_wdata;
        `DVS_REG_SAVE_CMD: begin
          // a save asked for while one runs is dropped; the pending file is the same
          if (reg_wdata == `DVS_SAVE_GO && !st_reg.save_busy) begin
            st_next.save_req = 1'b1;
            st_next.save_busy = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // judged on the next selection so a write of zero drops the main value at once
    if (st_next.main_sel == 16'h0000 || st_next.main_sel > `DVS_MAIN_SEL_MAX) begin
      st_next.main_on = 1'b0;
    end
    // a new save command outranks a stray done in the same cycle
    if (save_done && !st_reg.save_req && !st_next.save_req) begin
      st_next.save_busy = 1'b0;
    end
    unique case (reg_addr)
      `DVS_REG_MAIN_SEL: st_next.rdata = st_reg.main_sel;
      `DVS_REG_MAIN_UNIT: st_next.rdata = st_reg.main_unit;
      `DVS_REG_MAIN_GAIN: st_next.rdata = st_reg.main_gain;
      `DVS_REG_MAIN_OFFS: st_next.rdata = st_reg.main_offs;
      `DVS_REG_SAVE_CMD: st_next.rdata = {15'h0000, st_reg.save_busy};
      default: st_next.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '{phase: DVS_PH_BOOT, view: DVS_VIEW_LIVE, load_msg: DVS_MSG_NONE,
                  main_sel: `DVS_MAIN_SEL_RST, main_unit: `DVS_MAIN_UNIT_RST,
                  main_gain: `DVS_MAIN_GAIN_RST, main_offs: `DVS_MAIN_OFFS_RST,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  dvs_scaler #(.XW(XW)) u_scaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .x(meas_value),
    .gain(st_reg.main_gain),
    .offs(st_reg.main_offs),
    .y(main_value)
  );

  assign reg_rdata = st_reg.rdata;
  assign remember_qty = st_reg.qty;
  assign disp_qty = st_reg.main_on ? main_qty : st_reg.qty;
  assign meas_qty = disp_qty;
  assign disp_view = st_reg.view;
  assign icon_min = !st_reg.main_on && st_reg.view == DVS_VIEW_MIN;
  assign icon_max = !st_reg.main_on && st_reg.view == DVS_VIEW_MAX;
  assign show_main = st_reg.main_on;
  assign main_unit = st_reg.main_unit;
  assign save_req = st_reg.save_req;
  assign save_replace = st_reg.save_req;
  assign load_req = st_reg.load_req;
  // a load result outranks the cycled messages; they share the head of each slot
  assign disp_msg = (st_reg.load_msg != DVS_MSG_NONE) ? st_reg.load_msg :
                    (st_reg.msg_cnt >= 31'(MSG_SHOW_CYC)) ? DVS_MSG_NONE :
                    restore_needed ? DVS_MSG_RESTORE_REQ :
                    st_reg.done_seen ? DVS_MSG_DEFAULTS_DONE : DVS_MSG_NONE;

  sequence s_boot_hold;
    st_reg.phase == DVS_PH_BOOT && key_load_hold;
  endsequence
  sequence s_load_bad;
    st_reg.phase == DVS_PH_LOAD && load_done && !load_ok && !reg_wr;
  endsequence

  a_load_request: assert property (@(posedge clk_sys) disable iff (rst)
    s_boot_hold |=> load_req ##1 !load_req)
    else $error("held button at boot gave no single load request");
  a_load_fail_keep: assert property (@(posedge clk_sys) disable iff (rst)
    s_load_bad |=> $stable(st_reg.main_sel) && $stable(st_reg.main_gain) &&
      $stable(st_reg.main_offs) && disp_msg == DVS_MSG_LOAD_FAIL)
    else $error("failed load altered configuration");
  a_save_command: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `DVS_REG_SAVE_CMD && reg_wdata == `DVS_SAVE_GO &&
      !st_reg.save_busy |=> save_req && save_replace ##1 !save_req)
    else $error("save command not issued as one pulse");
  a_save_replace: assert property (@(posedge clk_sys) disable iff (rst)
    save_req |-> save_replace)
    else $error("save issued without replace");
  a_idle_restart: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.phase == DVS_PH_RUN && key_any |=> st_reg.idle_cnt == 31'h0 && !show_main)
    else $error("key press did not restart inactivity count");
  a_main_return: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.phase == DVS_PH_RUN && main_cfg && !show_main && !key_any && !reg_wr &&
      st_reg.idle_cnt == 31'(IDLE_CYC - 1) |=> show_main && disp_view == DVS_VIEW_LIVE)
    else $error("no return to main value after inactivity");
  a_main_zero_off: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.phase == DVS_PH_RUN && !main_cfg |-> !show_main)
    else $error("main value shown while none selected");
  a_icon_match: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.phase == DVS_PH_RUN && !show_main && key_max |=> icon_max && !icon_min)
    else $error("maximum key without maximum icon");
  a_temp_skipped: assert property (@(posedge clk_sys) disable iff (rst)
    !temp_fitted && st_reg.phase == DVS_PH_RUN && (key_next || key_prev) |=>
      disp_qty != `DVS_QTY_TEMP)
    else $error("temperature shown on unit without sensor");
  a_boot_main: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_wr && ((st_reg.phase == DVS_PH_BOOT && main_cfg) ||
      (st_reg.phase == DVS_PH_LOAD && load_done && load_ok && file_main_sel != 16'h0000 &&
      file_main_sel <= `DVS_MAIN_SEL_MAX)) |=> show_main)
    else $error("configured main value not shown at power-up");
endmodule
`default_nettype wire

//--- inc/dvs_regs.svh
// register numbers, reset values and timing figures of the display value selector
// assumes a 40 MHz system clock; register numbers are the serial register indices
`ifndef DVS_REGS_SVH
`define DVS_REGS_SVH

`define DVS_ADDR_W 16
`define DVS_DATA_W 16
`define DVS_REG_SAVE_CMD 16'h0fee
`define DVS_REG_MAIN_SEL 16'h1130
`define DVS_REG_MAIN_UNIT 16'h1131
`define DVS_REG_MAIN_GAIN 16'h1dc8
`define DVS_REG_MAIN_OFFS 16'h1dc9

`define DVS_SAVE_GO 16'h0001
`define DVS_MAIN_SEL_RST 16'h0000
`define DVS_MAIN_UNIT_RST 16'h0000
`define DVS_MAIN_GAIN_RST 16'h0001
`define DVS_MAIN_OFFS_RST 16'h0000

// list layout: index of the last entry, of temperature and of the last main choice
`define DVS_QTY_LAST 5'h15
`define DVS_QTY_TEMP 5'h0e
`define DVS_MAIN_SEL_MAX 16'h000f

`define DVS_CLK_HZ 40000000
`define DVS_IDLE_S 30
`define DVS_MSG_PERIOD_S 20
`define DVS_MSG_SHOW_S 2
`define DVS_IDLE_CYC (`DVS_IDLE_S * `DVS_CLK_HZ)
`define DVS_MSG_PERIOD_CYC (`DVS_MSG_PERIOD_S * `DVS_CLK_HZ)
`define DVS_MSG_SHOW_CYC (`DVS_MSG_SHOW_S * `DVS_CLK_HZ)

`endif

//--- inc/dvs_pkg.sv
// types shared by the display value selector files
// assumes dvs_regs.svh is compiled alongside
package dvs_pkg;
  typedef logic [4:0] dvs_qty_t;
  typedef logic [15:0] dvs_word_t;
  typedef enum logic [1:0] {DVS_VIEW_LIVE, DVS_VIEW_MIN, DVS_VIEW_MAX} dvs_view_e;
  typedef enum logic [2:0] {DVS_MSG_NONE, DVS_MSG_RESTORE_REQ, DVS_MSG_DEFAULTS_DONE,
                            DVS_MSG_LOAD_OK, DVS_MSG_LOAD_FAIL} dvs_msg_e;
  typedef enum logic [1:0] {DVS_PH_BOOT, DVS_PH_LOAD, DVS_PH_RUN} dvs_phase_e;
endpackage

//--- src/dvs_scaler.sv
// linear scaling of the main value: y = gain * x + offset, one cycle of latency
// assumes signed two's complement operands
`timescale 1ns/10ps
`default_nettype none
module dvs_scaler #(
  parameter int XW = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // operands
  input wire logic signed [XW-1:0] x,
  input wire logic signed [15:0] gain,
  input wire logic signed [15:0] offs,
  // result
  output logic signed [XW+16:0] y
);
  import dvs_pkg::*;
  typedef struct packed {
    logic signed [XW+16:0] y;
  } dvs_scl_s;
  dvs_scl_s st_reg;
  dvs_scl_s st_next;

  always_comb begin
    st_next.y = (XW+17)'(gain * x) + (XW+17)'(offs);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign y = st_reg.y;

  a_scale_result: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> y == (XW+17)'($past(gain) * $past(x)) + (XW+17)'($past(offs)))
    else $error("main value not gain times input plus offset");
endmodule
`default_nettype wire

//--- verif/dvs_panel_model.sv
// file store and measurement source standing behind the display value selector
// assumes requests are one-cycle pulses; answers are driven at falling edges
`timescale 1ns/10ps
`default_nettype none
module dvs_panel_model (
  // clock
  input wire logic clk_sys,
  // measurement
  input wire dvs_pkg::dvs_qty_t meas_qty,
  output logic signed [31:0] meas_value,
  // file store
  input wire logic save_req,
  input wire logic load_req,
  input wire logic load_good,
  output logic save_done,
  output logic load_done,
  output logic load_ok,
  output dvs_pkg::dvs_word_t file_main_sel,
  output dvs_pkg::dvs_word_t file_main_unit,
  output dvs_pkg::dvs_word_t file_main_gain,
  output dvs_pkg::dvs_word_t file_main_offs
);
  import dvs_pkg::*;
  int sd = 0;
  int ld = 0;
  int lat = 1;
  // each quantity gets its own distinct value so a wrong index shows up
  assign meas_value = 32'(meas_qty) * 7 + 100;
  initial begin
    {save_done, load_done, load_ok} = 3'h0;
    {file_main_sel, file_main_unit, file_main_gain, file_main_offs} = '1;
  end
  // answer delay alternates between prompt and slow
  always @(negedge clk_sys) begin
    save_done <= (sd == 1);
    load_done <= (ld == 1);
    // words are only valid with load_done; otherwise they keep toggling
    load_ok <= (ld == 1) ? load_good : ~load_ok;
    file_main_sel <= (ld == 1) ? 16'h0004 : ~file_main_sel;
    file_main_unit <= (ld == 1) ? 16'h0007 : ~file_main_unit;
    file_main_gain <= (ld == 1) ? 16'h0002 : ~file_main_gain;
    file_main_offs <= (ld == 1) ? 16'h0003 : ~file_main_offs;
    sd <= save_req ? lat : (sd > 0 ? sd - 1 : 0);
    ld <= load_req ? lat + 1 : (ld > 0 ? ld - 1 : 0);
    if (save_req || load_req) begin
      lat <= (lat == 1) ? 5 : 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/test_display_value_selector.sv
// self-checking bench for the display value selector with its panel model
// assumes shortened idle and message counts; notes are compared 2 ns after each fall
`timescale 1ns/10ps
`default_nettype none
`include "dvs_regs.svh"
module test_display_value_selector;
  import dvs_pkg::*;
  typedef struct {string nm; int sel; logic [48:0] exp;} dvs_note_s;
  logic clk_sys, rst, key_next, key_prev, key_min, key_max, key_load_hold, reg_wr;
  logic temp_fitted, restore_needed, defaults_done, load_good;
  logic icon_min, icon_max, show_main, save_req, save_replace, save_done;
  logic load_req, load_done, load_ok;
  logic [15:0] reg_addr;
  dvs_word_t reg_wdata, reg_rdata, main_unit;
  dvs_word_t file_main_sel, file_main_unit, file_main_gain, file_main_offs;
  dvs_qty_t saved_qty, remember_qty, meas_qty, disp_qty;
  dvs_view_e disp_view;
  dvs_msg_e disp_msg;
  logic signed [31:0] meas_value;
  logic signed [48:0] main_value, ev;
  logic signed [15:0] g, o;
  logic [31:0] rs;
  int err_total, total_checks, e;
  dvs_note_s q[$];
  logic [15:0] ra[5] = '{`DVS_REG_MAIN_SEL, `DVS_REG_MAIN_UNIT, `DVS_REG_MAIN_GAIN,
                         `DVS_REG_MAIN_OFFS, 16'h1234};
  logic [15:0] rv[5] = '{`DVS_MAIN_SEL_RST, `DVS_MAIN_UNIT_RST, `DVS_MAIN_GAIN_RST,
                         `DVS_MAIN_OFFS_RST, 16'h0000};

  dvs_selector #(.IDLE_CYC(50), .MSG_PERIOD_CYC(40), .MSG_SHOW_CYC(5), .XW(32))
    dvs_selector_inst (.clk_sys, .rst, .key_next, .key_prev, .key_min, .key_max,
    .key_load_hold, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .saved_qty, .temp_fitted,
    .remember_qty, .meas_qty, .meas_value, .disp_qty, .disp_view, .icon_min, .icon_max,
    .show_main, .main_unit, .main_value, .disp_msg, .restore_needed, .defaults_done,
    .save_req, .save_replace, .save_done, .load_req, .load_done, .load_ok, .file_main_sel,
    .file_main_unit, .file_main_gain, .file_main_offs);
  dvs_panel_model dvs_panel_model_inst (.clk_sys, .meas_qty, .meas_value, .save_req,
    .load_req, .load_good, .save_done, .load_done, .load_ok, .file_main_sel,
    .file_main_unit, .file_main_gain, .file_main_offs);

  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  function automatic logic [48:0] pick(int s);
    case (s)
      0: return 49'(disp_qty);
      1: return 49'(disp_view);
      2: return 49'(icon_min);
      3: return 49'(icon_max);
      4: return 49'(show_main);
      5: return 49'(main_unit);
      6: return main_value;
      7: return 49'(disp_msg);
      8: return 49'(reg_rdata);
      9: return 49'(save_req);
      10: return 49'(save_replace);
      default: return 49'(remember_qty);
    endcase
  endfunction
  task automatic check(string nm, logic [48:0] seen, logic [48:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic note(string nm, int sel, logic [48:0] exp);
    q.push_back('{nm, sel, exp});
  endtask
  task automatic done(string s);
    tick(1);
    $display("test %s finished", s);
  endtask
  task automatic boot(logic hold);
    rst = 1;
    key_load_hold = hold;
    tick(4);
    rst = 0;
    tick(3);
  endtask
  task automatic wr(logic [15:0] a, dvs_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
  endtask
  task automatic rd(string nm, logic [15:0] a, dvs_word_t x);
    reg_addr = a;
    tick(2);
    note(nm, 8, 49'(x));
  endtask
  // keys are one-cycle pulses; a cycle of rest keeps presses apart
  task automatic key(logic [3:0] k);
    {key_next, key_prev, key_min, key_max} = k;
    tick(1);
    {key_next, key_prev, key_min, key_max} = 4'h0;
    tick(1);
  endtask
  task automatic view(dvs_view_e v, logic mn, logic mx);
    note("view", 1, 49'(v));
    note("icon min", 2, 49'(mn));
    note("icon max", 3, 49'(mx));
  endtask
  task automatic wait_msg(dvs_msg_e m, int n);
    while (n > 0 && disp_msg !== m) begin
      tick(1);
      n--;
    end
    note("message", 7, 49'(m));
    tick(8);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // the observer checks every queued note, oldest first, once outputs have settled after the fall
  initial begin
    dvs_note_s t;
    forever begin
      @(negedge clk_sys);
      #2;
      while (q.size() > 0) begin
        t = q.pop_front();
        check(t.nm, pick(t.sel), t.exp);
      end
    end
  end

  initial begin
    tick(20000);
    err_total++;
    $display("[FAIL] watchdog expected finish seen timeout");
    final_report();
  end

  initial begin
    {key_next, key_prev, key_min, key_max, reg_wr, restore_needed, defaults_done} = 7'h0;
    {temp_fitted, load_good, reg_addr, reg_wdata} = '0;
    saved_qty = 5'h0c;
    rs = 32'h70d89e13;
    e = 13;
    boot(0);
    note("boot qty", 0, 49'h0c);
    note("boot main", 4, 49'h0);
    note("boot remember", 11, 49'h0c);
    foreach (ra[i]) rd("reg reset", ra[i], rv[i]);
    done("boot");
    temp_fitted = 1;
    key(4'b1000);
    key(4'b1000);
    note("temp fitted", 0, 49'h0e);
    temp_fitted = 0;
    key(4'b0100);
    note("temp back", 0, 49'h0d);
    for (int i = 0; i < 9; i++) begin
      e = (e == 21) ? 0 : e + 1;
      e = (e == 14) ? 15 : e;
      key(4'b1000);
      note("next qty", 0, 49'(e));
    end
    key(4'b0100);
    note("prev qty", 0, 49'h0);
    key(4'b0100);
    note("prev wrap", 0, 49'h15);
    key(4'b0010);
    view(DVS_VIEW_MIN, 1, 0);
    key(4'b0001);
    view(DVS_VIEW_MAX, 0, 1);
    key(4'b1000);
    view(DVS_VIEW_LIVE, 0, 0);
    tick(60);
    note("no main", 4, 49'h0);
    done("steps");
    rs = xs(rs);
    g = rs[15:0];
    rs = xs(rs);
    o = rs[15:0];
    ev = g * 49'sd114 + o;
    wr(`DVS_REG_MAIN_UNIT, 16'h0005);
    tick(1);
    wr(`DVS_REG_MAIN_GAIN, g);
    tick(1);
    wr(`DVS_REG_MAIN_OFFS, o);
    tick(1);
    wr(`DVS_REG_MAIN_SEL, 16'h0003);
    key(4'b1000);
    tick(40);
    note("idle early", 4, 49'h0);
    key(4'b1000);
    tick(45);
    note("idle restart", 4, 49'h0);
    tick(10);
    note("idle main", 4, 49'h1);
    note("main qty", 0, 49'h2);
    note("main unit", 5, 49'h5);
    note("main value", 6, ev);
    done("main value");
    wr(`DVS_REG_SAVE_CMD, 16'h0002);
    note("bad save", 9, 49'h0);
    tick(3);
    for (int i = 0; i < 2; i++) begin
      wr(`DVS_REG_SAVE_CMD, `DVS_SAVE_GO);
      note("save req", 9, 49'h1);
      note("save replace", 10, 49'h1);
      tick(1);
      wr(`DVS_REG_SAVE_CMD, `DVS_SAVE_GO);
      note("busy save", 9, 49'h0);
      tick(8);
    end
    done("save");
    restore_needed = 1;
    wait_msg(DVS_MSG_RESTORE_REQ, 45);
    note("restore keeps display", 4, 49'h1);
    restore_needed = 0;
    defaults_done = 1;
    tick(1);
    defaults_done = 0;
    repeat (2) wait_msg(DVS_MSG_DEFAULTS_DONE, 45);
    done("messages");
    boot(1);
    key_load_hold = 0;
    wait_msg(DVS_MSG_LOAD_FAIL, 20);
    rd("fail unit", `DVS_REG_MAIN_UNIT, `DVS_MAIN_UNIT_RST);
    load_good = 1;
    boot(1);
    key_load_hold = 0;
    wait_msg(DVS_MSG_LOAD_OK, 20);
    rd("load unit", `DVS_REG_MAIN_UNIT, 16'h0007);
    note("load main", 4, 49'h1);
    note("load main qty", 0, 49'h3);
    note("load remember", 11, 49'h0c);
    done("load");
    tick(2);
    final_report();
  end
endmodule
`default_nettype wire
